/* design/ofd_host.sv */
// Purpose: host service routine for the adapter trouble flag and laser-off request
// Assumes: trouble flag is open drain, pulled high on the host
// Notes:   one fault service per detection, result held until next service
//
// Contract
// - host samples flag level periodically
// - exactly one clear attempt per detection
// - resample first; clear means self-corrected
// - still low: request, wait clear delay
// - still low: release, report link-induced
// - cleared: module-induced, release, wait on-time
// - final sample: low means hard failure
// - request held at least 100 ns
// - host may ignore flag, tie request low
`default_nettype none
module ofd_host (
   // clock, reset, enable
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire logic                 clk_en,
   // control from host logic
   input  wire logic                 service_enable,
   // trouble flag pin, active low, input only
   input  wire logic                 trouble_flag_n,
   // laser-off request pin
   output logic                      laser_off_request_pin,
   // outcome
   output logic                      busy,
   output logic                      result_valid,
   output ofd_pkg::ofd_result_t      result,
   output logic                      link_service_req
);
   import ofd_pkg::*;

   typedef enum logic [2:0]
   {
      OFD_IDLE,
      OFD_RESAMPLE,
      OFD_DISABLE,
      OFD_RELEASE_WAIT,
      OFD_HOLDOFF
   } ofd_state_t;

   logic              rst_sync1_reg; // reset release stage 1
   logic              rst_n_reg;     // released reset copy
   logic              flag_low;      // synchronised flag asserted
   logic              flag_sync;     // synchronised raw level
   ofd_state_t        state_reg;     // service routine state
   logic [TMR_W-1:0]  tmr_reg;       // wait counter
   logic [TMR_W-1:0]  poll_reg;      // poll spacing counter
   logic              poll_tick;     // periodic sample strobe
   logic              armed_reg;     // detection may start a service

   // reset release through two flops
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_sync1_reg <= 1'b0;
         rst_n_reg     <= 1'b0;
      end
      else
      begin
         rst_sync1_reg <= 1'b1;
         rst_n_reg     <= rst_sync1_reg;
      end
   end

   // flag synchroniser, idles released (high)
   ofd_sync #(.RST_VAL(1'b1)) u_flag_sync (
      .clock (clock),
      .rst_n (rst_n_reg),
      .ce    (clk_en),
      .d     (trouble_flag_n),
      .q     (flag_sync)
   );
   assign flag_low = ~flag_sync;

   // periodic sampling of the flag level, not its edge
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         poll_reg <= '0;
      else if (clk_en)
      begin
         if (poll_tick)
            poll_reg <= '0;
         else
            poll_reg <= poll_reg + 1'b1;
      end
   end
   assign poll_tick = (poll_reg == TMR_W'(POLL_CYC - 1));

   // armed: a level seen low again only counts after a clean high sample,
   // so a lingering link fault does not trigger repeated clear attempts
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         armed_reg <= 1'b1;
      else if (clk_en)
      begin
         if (state_reg == OFD_IDLE && poll_tick && !flag_low)
            armed_reg <= 1'b1;
         else if (state_reg == OFD_IDLE && poll_tick && flag_low && service_enable)
            armed_reg <= 1'b0;
      end
   end

   // service routine; waits counted in host clocks
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg             <= OFD_IDLE;
         tmr_reg               <= '0;
         laser_off_request_pin <= 1'b0;
         result                <= OFD_NONE;
         result_valid          <= 1'b0;
         link_service_req      <= 1'b0;
      end
      else if (clk_en)
      begin
         result_valid <= 1'b0;
         case (state_reg)
            OFD_IDLE:
            begin
               // disabled host leaves request low and ignores flag
               if (service_enable && poll_tick && flag_low && armed_reg)
                  state_reg <= OFD_RESAMPLE;
            end
            OFD_RESAMPLE:
            begin
               if (!flag_low)
               begin
                  result       <= OFD_SELF_CORRECTED;
                  result_valid <= 1'b1;
                  state_reg    <= OFD_IDLE;
               end
               else
               begin
                  laser_off_request_pin <= 1'b1;
                  link_service_req      <= 1'b0;
                  tmr_reg               <= '0;
                  state_reg             <= OFD_DISABLE;
               end
            end
            OFD_DISABLE:
            begin
               // clear delay covers the 100 ns least pulse too; two extra cycles
               // cover the synchroniser lag, so the level judged here is at least
               // the clear delay old when the request drops
               if (tmr_reg == TMR_W'(CLEAR_CYC + 1))
               begin
                  laser_off_request_pin <= 1'b0;
                  tmr_reg               <= '0;
                  if (flag_low)
                  begin
                     result           <= OFD_LINK_INDUCED;
                     result_valid     <= 1'b1;
                     link_service_req <= 1'b1;
                     state_reg        <= OFD_IDLE;
                  end
                  else
                     state_reg <= OFD_RELEASE_WAIT;
               end
               else
                  tmr_reg <= tmr_reg + 1'b1;
            end
            OFD_RELEASE_WAIT:
            begin
               // one cycle beyond the on time plus the hold-off step: the flag
               // seen in hold-off is sampled a full on time after release
               if (tmr_reg == TMR_W'(LASER_ON_CYC))
                  state_reg <= OFD_HOLDOFF;
               else
                  tmr_reg <= tmr_reg + 1'b1;
            end
            OFD_HOLDOFF:
            begin
               result       <= flag_low ? OFD_HARD_FAILURE : OFD_MODULE_CORRECTED;
               result_valid <= 1'b1;
               tmr_reg      <= '0;
               state_reg    <= OFD_IDLE;
            end
            default:
               state_reg <= OFD_IDLE;
         endcase
      end
   end

   assign busy = (state_reg != OFD_IDLE);

   // request pulse held at least 8 cycles, past the 100 ns least pulse
   a_req_width: assert property (@(posedge clock) disable iff (!rst_n_reg)
      $rose(laser_off_request_pin) |-> laser_off_request_pin [*8]);
   // request only raised from the resample step
   a_req_cause: assert property (@(posedge clock) disable iff (!rst_n_reg)
      $rose(laser_off_request_pin) |-> $past(state_reg) == OFD_RESAMPLE);
   // request low whenever idle
   a_idle_req: assert property (@(posedge clock) disable iff (!rst_n_reg)
      state_reg == OFD_IDLE |-> !laser_off_request_pin);

   // outcome reported as link-induced
   sequence s_link_outcome;
      result_valid && result == OFD_LINK_INDUCED;
   endsequence

   // request drops only at the sample after the clear delay
   a_req_release: assert property (@(posedge clock) disable iff (!rst_n_reg)
      $fell(laser_off_request_pin) |->
         (state_reg == OFD_RELEASE_WAIT) || (result_valid && result == OFD_LINK_INDUCED))
      else $error("request dropped outside the clear sample");
   // link-induced outcome hands over to link servicing
   a_link_handover: assert property (@(posedge clock) disable iff (!rst_n_reg)
      s_link_outcome |-> link_service_req)
      else $error("link outcome without link service request");
   // self-corrected fault leaves the request untouched
   a_self_quiet: assert property (@(posedge clock) disable iff (!rst_n_reg)
      result_valid && result == OFD_SELF_CORRECTED |-> !laser_off_request_pin)
      else $error("request high on a self-corrected outcome");
   // disabled service never leaves idle
   a_off_quiet: assert property (@(posedge clock) disable iff (!rst_n_reg)
      state_reg == OFD_IDLE && !service_enable |=> state_reg == OFD_IDLE)
      else $error("service started while disabled");
endmodule : ofd_host
`default_nettype wire

/* design/ofd_pkg.sv */
// Purpose: shared constants for the host-side fault service controller
// Assumes: 25 MHz host clock
// Notes:   times kept in their own units, cycle counts derived here
`default_nettype none
package ofd_pkg;
   localparam int unsigned CLOCK_HZ            = 25000000; // host clock rate
   localparam int unsigned T_FLAG_CLEAR_NS     = 1000;     // clear delay, 1 us
   localparam int unsigned T_MIN_DISABLE_NS    = 100;      // least request pulse
   localparam int unsigned T_LASER_ON_MS       = 2;        // laser on time
   localparam int unsigned T_POLL_US           = 100;      // periodic sample spacing
   // least times round up to whole cycles
   localparam int unsigned CLEAR_CYC =
      (T_FLAG_CLEAR_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned PULSE_CYC =
      (T_MIN_DISABLE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned LASER_ON_CYC = T_LASER_ON_MS * (CLOCK_HZ / 1000);
   localparam int unsigned POLL_CYC     = T_POLL_US * (CLOCK_HZ / 1000000);
   localparam int unsigned TMR_W        = 24;          // wait counter width
   // outcome codes
   typedef enum logic [2:0]
   {
      OFD_NONE,
      OFD_SELF_CORRECTED,
      OFD_LINK_INDUCED,
      OFD_MODULE_CORRECTED,
      OFD_HARD_FAILURE
   } ofd_result_t;
endpackage : ofd_pkg
`default_nettype wire

/* design/ofd_sync.sv */
// Purpose: two-stage level synchroniser for the trouble flag
// Assumes: constant reset value given by parameter
// Notes:   first stage read only by the second
`default_nettype none
module ofd_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic ce,
   // data
   input  wire logic d,
   output logic      q
);
   logic meta_reg; // first stage, metastability catcher

   // two flops; reset value is a constant
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end
      else if (ce)
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : ofd_sync
`default_nettype wire

/* verif/ofd_adapter_model.sv */
// Purpose: behavioural adapter at the far end of the fault flag and laser-off pins
// Assumes: flag is open drain with a host pull-up, so released reads high
// Notes:   no clock inside; timing kept as plain delays
`default_nettype none
module ofd_adapter_model #(
   parameter int CLEAR_NS = 300 // flag release after request, under 1 us
) (
   // host side
   input  wire logic laser_off_request_pin,
   // fault causes from the bench
   input  wire logic fault_event,
   input  wire logic light_loss,
   input  wire logic stuck_fault,
   // adapter outputs
   output logic      trouble_flag_n,
   output logic      laser_on
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mod_fault_reg = 1'b0; // latched module fault
   // latch, clear on request rise, relatch on fall if the fault is real
   always @(posedge fault_event or posedge laser_off_request_pin or
            negedge laser_off_request_pin)
   begin
      if (laser_off_request_pin)
         mod_fault_reg <= #(CLEAR_NS) 1'b0;
      else if (fault_event || stuck_fault)
         mod_fault_reg <= 1'b1;
   end
   // open drain: pulled low on any fault, else the pull-up wins
   assign trouble_flag_n = !(mod_fault_reg || light_loss);
   // laser dark while requested; restarts on release unless a stuck fault relatches
   assign laser_on = !laser_off_request_pin && !mod_fault_reg;
endmodule : ofd_adapter_model
`default_nettype wire

/* verif/optical_fault_disable_handshake_tb_top.sv */
// Purpose: self-checking bench for the host fault service routine
// Assumes: enable on except one disabled stretch in the link test; long 2 ms wait run at full length
// Notes:   request pulse width counted while awaiting the link and module outcomes
`default_nettype none
module optical_fault_disable_handshake_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ofd_pkg::*;
   logic        clock = 1'b0;  // 25 MHz
   logic        arst_n = 1'b0; // async reset
   logic        service_enable = 1'b1;
   logic        fault_event = 1'b0;
   logic        light_loss = 1'b0;
   logic        stuck_fault = 1'b0;
   wire logic   trouble_flag_n;
   wire logic   laser_off_request_pin;
   wire logic   busy;
   wire logic   result_valid;
   ofd_result_t result;
   wire logic   link_service_req;
   int          mismatches = 0;
   int          comparisons = 0;
   int          high_cyc; // request high cycles in last wait
   always #20 clock = ~clock;
   ofd_host dut_u (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
      .service_enable(service_enable), .trouble_flag_n(trouble_flag_n),
      .laser_off_request_pin(laser_off_request_pin), .busy(busy),
      .result_valid(result_valid), .result(result), .link_service_req(link_service_req));
   ofd_adapter_model adapter_u (.laser_off_request_pin(laser_off_request_pin),
      .fault_event(fault_event), .light_loss(light_loss), .stuck_fault(stuck_fault),
      .trouble_flag_n(trouble_flag_n), .laser_on());
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   // wait for an outcome, counting request cycles; a spent bound ends the run
   task automatic await_result(input int bound);
      high_cyc = 0;
      for (int i = 0; i <= bound; i++)
      begin
         @(posedge clock);
         #1;
         if (laser_off_request_pin === 1'b1)
            high_cyc++;
         if (result_valid === 1'b1)
            return;
      end
      check("result_valid timeout", 32'h0, 32'h1);
      summarize();
   endtask : await_result
   task automatic idle_cycles(input int n, input logic exp_req);
      repeat (n)
      begin
         @(posedge clock);
         #1;
         if (laser_off_request_pin !== exp_req)
            check("idle request", laser_off_request_pin, exp_req);
      end
   endtask : idle_cycles
   task automatic test_link;
      light_loss <= 1'b1;
      await_result(POLL_CYC + 100);
      check("link result", result, OFD_LINK_INDUCED);
      check("link service", link_service_req, 1'b1);
      check("link pulse", high_cyc, CLEAR_CYC + 2);
      // fault persists: no second attempt, and disabled service stays quiet
      idle_cycles(POLL_CYC + 100, 1'b0);
      service_enable <= 1'b0;
      idle_cycles(POLL_CYC + 100, 1'b0);
      light_loss <= 1'b0;
      service_enable <= 1'b1;
      idle_cycles(POLL_CYC + 100, 1'b0);
      $display("test link done");
   endtask : test_link
   // flag low one cycle in three: some poll sees it low, its resample high
   task automatic test_self;
      logic got;
      got = 1'b0;
      for (int i = 0; i < 3 * POLL_CYC + 100 && !got; i++)
      begin
         @(posedge clock);
         light_loss <= (i % 3 == 0);
         #1;
         got = (result_valid === 1'b1);
      end
      @(posedge clock);
      light_loss <= 1'b0;
      #1;
      if (!got)
      begin
         check("self timeout", 32'h0, 32'h1);
         summarize();
      end
      else
      begin
         check("self result", result, OFD_SELF_CORRECTED);
         check("self request", laser_off_request_pin, 1'b0);
         idle_cycles(POLL_CYC + 100, 1'b0);
         $display("test self done");
      end
   endtask : test_self
   task automatic test_module(input logic stuck, input ofd_result_t exp);
      stuck_fault <= stuck;
      fault_event <= 1'b1;
      @(posedge clock);
      fault_event <= 1'b0;
      await_result(POLL_CYC + CLEAR_CYC + LASER_ON_CYC + 100);
      check("module result", result, exp);
      check("module pulse", high_cyc, CLEAR_CYC + 2);
      check("module no link", link_service_req, 1'b0);
      stuck_fault <= 1'b0;
      @(posedge clock);
      // a stuck fault relatches on release and keeps the flag low
      check("module flag", trouble_flag_n, !stuck);
      idle_cycles(POLL_CYC + 100, 1'b0);
      $display("test module done");
   endtask : test_module
   initial
   begin
      repeat (12) @(posedge clock);
      #1;
      check("reset request", laser_off_request_pin, 1'b0);
      check("reset result", result, OFD_NONE);
      check("reset busy", busy, 1'b0);
      arst_n <= 1'b1;
      idle_cycles(10, 1'b0);
      test_link();
      test_self();
      test_module(1'b0, OFD_MODULE_CORRECTED);
      test_module(1'b1, OFD_HARD_FAILURE);
      summarize();
   end
endmodule : optical_fault_disable_handshake_tb_top
`default_nettype wire
